// ---- filter_cfg_pkg.sv ----
`default_nettype none
package filter_cfg_pkg;
    localparam int CFG_WIDTH        = 16;
    localparam int BIT_SINGLE       = 15;
    localparam int RATE_HI          = 14;
    localparam int RATE_LO          = 13;
    localparam int BIT_DECIMATE     = 12;
    localparam int ROLE_HI          = 11;
    localparam int ROLE_LO          = 10;
    localparam int BIT_BANK_BY_WORD = 7;
    localparam int BIT_BANK_UPPER   = 6;
    localparam int BIT_BANK_ALT     = 5;
    localparam int BIT_CASCADE      = 4;
    localparam logic [15:0] CFG_RESERVED_MASK = 16'h030F;
    localparam logic [15:0] CFG_RESET         = 16'h0000;
    localparam int EPROM_CFG_BYTES  = 2;
    localparam int DIV_WIDTH        = 3;
    typedef enum logic [1:0] {
        FILTER_DUAL_INDEPENDENT,
        FILTER_DUAL_CASCADE,
        FILTER_SINGLE
    } filter_mode_e;
endpackage
`default_nettype wire

// ---- sample_tick_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface sample_tick_if;
    logic [1:0] rate_sel;
    logic       tick;
    modport gen (input rate_sel, output tick);
    modport use_side (output rate_sel, input tick);
endinterface
`default_nettype wire

// ---- sample_tick_gen.sv ----
`timescale 1ns/1ps
`default_nettype none
module sample_tick_gen (
    input  wire logic      clk_in,
    input  wire logic      rst_n_in,
    sample_tick_if.gen     tk
);
    logic [filter_cfg_pkg::DIV_WIDTH-1:0] cnt_q;
    logic [filter_cfg_pkg::DIV_WIDTH-1:0] cnt_d;
    logic [filter_cfg_pkg::DIV_WIDTH-1:0] limit;
    logic                                 tick_q;
    logic                                 tick_d;

    // Divide by 1, 2, 4 or 8 of the system clock
    always_comb begin
        limit = 3'((1 << tk.rate_sel) - 1);
        tick_d = (cnt_q >= limit);
        cnt_d = tick_d ? 3'h0 : 3'(cnt_q + 3'h1);
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cnt_q  <= 3'h0;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tk.tick = tick_q;
endmodule
`default_nettype wire

// ---- filter_configuration.sv ----
// What this block does
// - One 16-bit word holds all configuration and governs both networks.
// - A written word lands in a pending copy and leaves the active copy alone.
// - A toggle of the bank-swap signal moves the pending copy to active.
// - The first word written after reset goes straight into the active copy.
// - Bit 15 picks single filter, else bit 4 picks independent or cascade.
// - Bits 14:13 divide the sample rate by 1, 2, 4 or 8.
// - Bit 12 enables decimation by two.
// - Bits 11:10 give the cascade role of the device.
// - Bit 7 clear follows the bank pin, set follows bit 6.
// - With bit 7 set and bit 5 clear, bit 6 picks lower or upper bank.
// - Bit 5 set alternates banks every sample clock regardless of 7 and 6.
// - The EPROM loader drives the word select high for the first two bytes.
`timescale 1ns/1ps
`default_nettype none
module filter_configuration (
    input  wire logic        MCLK_IN,
    input  wire logic        RESETN_IN,
    input  wire logic        WRITE_EN_IN,
    input  wire logic        BYTE_MODE_IN,
    input  wire logic        BYTE_HIGH_IN,
    input  wire logic [15:0] WDATA_IN,
    input  wire logic        CONFIG_WORD_SELECT_IN,
    input  wire logic        EPROM_LOAD_IN,
    input  wire logic        EPROM_BYTE_STROBE_IN,
    input  wire logic        BANK_SWAP_IN,
    input  wire logic        BANK_PIN_IN,
    output logic             CONFIG_WORD_SELECT_OUT,
    output logic [15:0]      ACTIVE_CFG_OUT,
    output logic [15:0]      PENDING_CFG_OUT,
    output logic [1:0]       FILTER_MODE_OUT,
    output logic [1:0]       RATE_SEL_OUT,
    output logic             DECIMATE_OUT,
    output logic [1:0]       ROLE_OUT,
    output logic             UPPER_BANK_OUT,
    output logic             SAMPLE_TICK_OUT,
    output logic             RESERVED_ERR_OUT
);
    // ------------------------------------------------------------
    // Word capture
    // ------------------------------------------------------------
    logic [15:0] pending_q, pending_d;
    logic [15:0] active_q, active_d;
    logic        first_q, first_d;
    logic        swap_s_q, swap_s_d;
    logic        swap_pend_q, swap_pend_d;
    logic        low_ok_q, low_ok_d;
    logic [1:0]  ebytes_q, ebytes_d;
    logic        ccs_q, ccs_d;
    logic        alt_q, alt_d;
    logic        bank_q, bank_d;
    logic        rerr_q, rerr_d;
    logic [15:0] word;
    logic        word_done;
    logic        cfg_wr;

    // Sample tick divider runs off the active rate field
    sample_tick_if tk ();

    sample_tick_gen u_tick (
        .clk_in   (MCLK_IN),
        .rst_n_in (RESETN_IN),
        .tk       (tk)
    );

    // Rate divider follows the active copy only
    assign tk.rate_sel = active_q[filter_cfg_pkg::RATE_HI:
                                  filter_cfg_pkg::RATE_LO];

    always_comb begin
        pending_d   = pending_q;
        active_d    = active_q;
        first_d     = first_q;
        low_ok_d    = low_ok_q;
        ebytes_d    = ebytes_q;
        word        = pending_q;
        word_done   = 1'b0;
        rerr_d      = rerr_q;
        // Byte count restarts whenever the loader role is dropped
        if (!EPROM_LOAD_IN) begin
            ebytes_d = 2'h0;
        end
        // A host write is ignored while the device runs its own loader
        cfg_wr = EPROM_LOAD_IN ? (EPROM_BYTE_STROBE_IN && ccs_q)
                               : (WRITE_EN_IN && CONFIG_WORD_SELECT_IN);
        if (EPROM_LOAD_IN && EPROM_BYTE_STROBE_IN && ccs_q) begin
            ebytes_d = 2'(ebytes_q + 2'h1);
        end
        // Select high for the first two EPROM byte transfers; it drops
        // straight after the second, so a following strobe is a coefficient
        ccs_d = EPROM_LOAD_IN &&
                (ebytes_d < 2'(filter_cfg_pkg::EPROM_CFG_BYTES));
        // Bytes arrive low first; the word completes on the high byte
        if (cfg_wr) begin
            if (EPROM_LOAD_IN || BYTE_MODE_IN) begin
                if (EPROM_LOAD_IN ? ebytes_q[0] : BYTE_HIGH_IN) begin
                    word = {WDATA_IN[7:0], pending_q[7:0]};
                    word_done = low_ok_q;
                    low_ok_d  = 1'b0;
                end else begin
                    word = {pending_q[15:8], WDATA_IN[7:0]};
                    low_ok_d = 1'b1;
                end
            end else begin
                word = WDATA_IN;
                word_done = 1'b1;
            end
            pending_d = word;
        end
        if (word_done) begin
            // Writer owns the reserved bits; flag but do not block
            rerr_d = |(word & filter_cfg_pkg::CFG_RESERVED_MASK);
            if (first_q) begin
                active_d = word;
                first_d  = 1'b0;
            end
        end
        // Transfer one cycle after the detected toggle; the sampler resets
        // low, so a swap level held high at release counts as a toggle
        swap_s_d    = BANK_SWAP_IN;
        swap_pend_d = (swap_s_q != BANK_SWAP_IN);
        if (swap_pend_q) begin
            active_d = pending_q;
        end
    end

    // Registers only; every next value comes from the block above
    always_ff @(posedge MCLK_IN) begin
        if (!RESETN_IN) begin
            pending_q   <= filter_cfg_pkg::CFG_RESET;
            active_q    <= filter_cfg_pkg::CFG_RESET;
            first_q     <= 1'b1;
            swap_s_q    <= 1'b0;
            swap_pend_q <= 1'b0;
            low_ok_q    <= 1'b0;
            ebytes_q    <= 2'h0;
            ccs_q       <= 1'b0;
            rerr_q      <= 1'b0;
        end else begin
            pending_q   <= pending_d;
            active_q    <= active_d;
            first_q     <= first_d;
            swap_s_q    <= swap_s_d;
            swap_pend_q <= swap_pend_d;
            low_ok_q    <= low_ok_d;
            ebytes_q    <= ebytes_d;
            ccs_q       <= ccs_d;
            rerr_q      <= rerr_d;
        end
    end

    // ------------------------------------------------------------
    // Bank selection
    // ------------------------------------------------------------
    always_comb begin
        alt_d  = alt_q;
        if (tk.tick) begin
            alt_d = !alt_q;
        end
        // Alternation takes priority over both the pin and bit 6
        if (active_q[filter_cfg_pkg::BIT_BANK_ALT]) begin
            bank_d = alt_q;
        end else if (active_q[filter_cfg_pkg::BIT_BANK_BY_WORD]) begin
            bank_d = active_q[filter_cfg_pkg::BIT_BANK_UPPER];
        end else begin
            bank_d = BANK_PIN_IN;
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (!RESETN_IN) begin
            alt_q  <= 1'b0;
            bank_q <= 1'b0;
        end else begin
            alt_q  <= alt_d;
            bank_q <= bank_d;
        end
    end

    // ------------------------------------------------------------
    // Decoded outputs
    // ------------------------------------------------------------
    // Mode is registered so the networks see one settled code per cycle
    logic [1:0] mode_q;
    logic [1:0] mode_d;

    always_comb begin
        if (active_q[filter_cfg_pkg::BIT_SINGLE]) begin
            mode_d = 2'(filter_cfg_pkg::FILTER_SINGLE);
        end else if (active_q[filter_cfg_pkg::BIT_CASCADE]) begin
            mode_d = 2'(filter_cfg_pkg::FILTER_DUAL_CASCADE);
        end else begin
            mode_d = 2'(filter_cfg_pkg::FILTER_DUAL_INDEPENDENT);
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (!RESETN_IN) begin
            mode_q <= 2'(filter_cfg_pkg::FILTER_DUAL_INDEPENDENT);
        end else begin
            mode_q <= mode_d;
        end
    end

    // Mode, rate, decimation and role fields come from the single active word
    assign ACTIVE_CFG_OUT  = active_q;
    assign PENDING_CFG_OUT = pending_q;
    assign FILTER_MODE_OUT = mode_q;
    assign RATE_SEL_OUT    = active_q[filter_cfg_pkg::RATE_HI:
                                      filter_cfg_pkg::RATE_LO];
    assign DECIMATE_OUT    = active_q[filter_cfg_pkg::BIT_DECIMATE];
    assign ROLE_OUT        = active_q[filter_cfg_pkg::ROLE_HI:
                                      filter_cfg_pkg::ROLE_LO];
    assign UPPER_BANK_OUT  = bank_q;
    assign SAMPLE_TICK_OUT = tk.tick;
    assign RESERVED_ERR_OUT = rerr_q;
    assign CONFIG_WORD_SELECT_OUT = ccs_q;
endmodule
`default_nettype wire

// ---- filter_configuration_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module filter_configuration_assertions (
    input wire logic        MCLK_IN,
    input wire logic        RESETN_IN,
    input wire logic        WRITE_EN_IN,
    input wire logic        BYTE_MODE_IN,
    input wire logic        CONFIG_WORD_SELECT_IN,
    input wire logic        EPROM_LOAD_IN,
    input wire logic        EPROM_BYTE_STROBE_IN,
    input wire logic        BANK_SWAP_IN,
    input wire logic        BANK_PIN_IN,
    input wire logic [15:0] WDATA_IN,
    input wire logic        CONFIG_WORD_SELECT_OUT,
    input wire logic [15:0] ACTIVE_CFG_OUT,
    input wire logic [15:0] PENDING_CFG_OUT,
    input wire logic [1:0]  FILTER_MODE_OUT,
    input wire logic [1:0]  RATE_SEL_OUT,
    input wire logic        DECIMATE_OUT,
    input wire logic [1:0]  ROLE_OUT,
    input wire logic        UPPER_BANK_OUT,
    input wire logic        SAMPLE_TICK_OUT
);
    default clocking @(posedge MCLK_IN); endclocking
    default disable iff (!RESETN_IN);
    sequence word_write;
        WRITE_EN_IN && CONFIG_WORD_SELECT_IN && !EPROM_LOAD_IN && !BYTE_MODE_IN;
    endsequence
    sequence two_bytes;
        EPROM_LOAD_IN && EPROM_BYTE_STROBE_IN && CONFIG_WORD_SELECT_OUT ##1
        EPROM_LOAD_IN && EPROM_BYTE_STROBE_IN;
    endsequence
    chk_pending_word: assert property (word_write |=>
        PENDING_CFG_OUT == $past(WDATA_IN)) else $error("pending word lost");
    chk_swap_moves: assert property ($changed(BANK_SWAP_IN) |->
        ##[1:3] ACTIVE_CFG_OUT == PENDING_CFG_OUT) else $error("swap missed");
    chk_field_map: assert property ({RATE_SEL_OUT, DECIMATE_OUT,
        ROLE_OUT} == ACTIVE_CFG_OUT[14:10]) else $error("field outputs wrong");
    chk_mode_decode: assert property (1'b1 |=> FILTER_MODE_OUT ==
        ($past(ACTIVE_CFG_OUT[15]) ? 2'h2 : {1'b0, $past(ACTIVE_CFG_OUT[4])}))
        else $error("filter mode wrong");
    chk_bank_word: assert property (ACTIVE_CFG_OUT[7:5] inside {3'h4, 3'h6}
        |=> UPPER_BANK_OUT == $past(ACTIVE_CFG_OUT[6])) else $error("word bank");
    chk_bank_pin: assert property (ACTIVE_CFG_OUT[7:5] inside {3'h0, 3'h2}
        |=> UPPER_BANK_OUT == $past(BANK_PIN_IN)) else $error("pin bank wrong");
    chk_bank_alt: assert property (ACTIVE_CFG_OUT[5] && SAMPLE_TICK_OUT |->
        ##[1:2] $changed(UPPER_BANK_OUT)) else $error("bank did not alternate");
    // Rate must be settled a cycle first: a rate change may restart the count
    chk_tick_eighth: assert property (SAMPLE_TICK_OUT && RATE_SEL_OUT == 2'h3
        && $past(RATE_SEL_OUT) == 2'h3 |=> (!SAMPLE_TICK_OUT || RATE_SEL_OUT != 2'h3)
        [*7] ##1 (SAMPLE_TICK_OUT || RATE_SEL_OUT != 2'h3)) else $error("tick gap");
    chk_eprom_word: assert property (two_bytes |=> PENDING_CFG_OUT ==
        {$past(WDATA_IN[7:0]), $past(WDATA_IN[7:0], 2)}
        ##[0:1] !CONFIG_WORD_SELECT_OUT) else $error("loader word wrong");
    chk_select_idle: assert property (!EPROM_LOAD_IN |=>
        !CONFIG_WORD_SELECT_OUT) else $error("select high without loader");
endmodule
`default_nettype wire

// ---- cfg_writer_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module cfg_writer_model (
    input  wire logic   clk_in,
    input  wire logic   select_in,
    output logic        wr_out,
    output logic        byte_mode_out,
    output logic        byte_hi_out,
    output logic        ccs_out,
    output logic        eprom_out,
    output logic        strobe_out,
    output logic [15:0] data_out
);
    initial begin
        {wr_out, byte_mode_out, byte_hi_out, ccs_out, eprom_out, strobe_out} = '0;
        data_out = 16'h0000;
    end
    // Idle data is the inverse, so a stale word never looks valid
    task automatic put(input logic [4:0] ctl, input logic [15:0] d);
        @(posedge clk_in);
        {wr_out, byte_mode_out, byte_hi_out, ccs_out, strobe_out} <= ctl;
        data_out <= d;
    endtask
    task automatic host_word(input logic [15:0] w, input logic c);
        put({1'b1, 2'h0, c, 1'b0}, w);
        put(5'h00, ~w);
        put(5'h00, ~w);
    endtask
    task automatic host_bytes(input logic [15:0] w);
        put(5'h1A, {8'h00, w[7:0]});
        put(5'h1E, {8'h00, w[15:8]});
        put(5'h00, ~w);
        put(5'h00, ~w);
    endtask
    task automatic eprom_word(input logic [15:0] w, input int gap);
        int n;
        n = 0;
        @(posedge clk_in);
        eprom_out <= 1'b1;
        while (!select_in && n < 8) begin
            @(posedge clk_in);
            n++;
        end
        put(5'h01, {8'h00, w[7:0]});
        repeat (gap) put(5'h00, ~w);
        put(5'h01, {8'h00, w[15:8]});
        repeat (3) put(5'h00, ~w);
        eprom_out <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- filter_configuration_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module filter_configuration_tb;
    logic        mclk, resetn, swap, pin, wr, bm, bh, config_word_select, ep, stb, sel;
    logic        dec, upper, tick, rerr;
    logic [15:0] data, act, pend, prev;
    logic [1:0]  mode, rate, role;
    logic [19:0] r;
    int          errors = 0, check_count = 0;
    logic [19:0] rows [7] = '{20'h8_C108, 20'h2_4104, 20'h5_8000, 20'h0_0C02,
                              20'h0_0800, 20'h0_3011, 20'h6_0000};
    filter_configuration u_filter_configuration (.MCLK_IN(mclk),
        .RESETN_IN(resetn), .WRITE_EN_IN(wr), .BYTE_MODE_IN(bm),
        .BYTE_HIGH_IN(bh), .WDATA_IN(data), .CONFIG_WORD_SELECT_IN(config_word_select),
        .EPROM_LOAD_IN(ep), .EPROM_BYTE_STROBE_IN(stb), .BANK_SWAP_IN(swap),
        .BANK_PIN_IN(pin), .CONFIG_WORD_SELECT_OUT(sel), .ACTIVE_CFG_OUT(act),
        .PENDING_CFG_OUT(pend), .FILTER_MODE_OUT(mode), .RATE_SEL_OUT(rate),
        .DECIMATE_OUT(dec), .ROLE_OUT(role), .UPPER_BANK_OUT(upper),
        .SAMPLE_TICK_OUT(tick), .RESERVED_ERR_OUT(rerr));
    cfg_writer_model u_cfg_writer_model (.clk_in(mclk), .select_in(sel),
        .wr_out(wr), .byte_mode_out(bm), .byte_hi_out(bh), .ccs_out(config_word_select),
        .eprom_out(ep), .strobe_out(stb), .data_out(data));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic do_reset();
        @(posedge mclk);
        resetn <= 1'b0;
        swap <= 1'b0;
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
    endtask
    task automatic wrap_up();
        $display("errors=%0d checks=%0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge mclk);
        errors++;
        wrap_up();
    end
    initial begin
        logic        u;
        logic [15:0] n;
        resetn = 1'b0;
        swap = 1'b0;
        pin = 1'b0;
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        u_cfg_writer_model.host_word(16'h0000, 1'b1);
        prev = 16'h0000;
        for (int i = 0; i < 7; i++) begin
            r = rows[i];
            u_cfg_writer_model.host_word(r[19:4], 1'b1);
            check(pend, r[19:4]);
            check(act, prev);
            @(posedge mclk);
            swap <= ~swap;
            settle(4);
            check(act, r[19:4]);
            check({14'h0, mode}, {14'h0, r[3:2]});
            check({15'h0, upper}, {15'h0, r[1]});
            check({15'h0, rerr}, {15'h0, r[0]});
            check({14'h0, rate}, {14'h0, r[18:17]});
            check({15'h0, dec}, {15'h0, r[16]});
            check({14'h0, role}, {14'h0, r[15:14]});
            n = 16'h0000;
            repeat (8) begin
                settle(1);
                n = n + 16'(tick);
            end
            check(n, 16'(8 >> r[18:17]));
            prev = r[19:4];
        end
        @(posedge mclk);
        pin <= 1'b1;
        settle(2);
        check({15'h0, upper}, 16'h0001);
        u_cfg_writer_model.host_word(16'h4400, 1'b0);
        check(pend, 16'h6000);
        u_cfg_writer_model.host_bytes(16'h6C90);
        check(pend, 16'h6C90);
        @(posedge mclk);
        swap <= ~swap;
        settle(12);
        check(act, 16'h6C90);
        check({15'h0, upper}, 16'h0000);
        check({14'h0, mode}, 16'h0001);
        u_cfg_writer_model.host_word(16'h0020, 1'b1);
        @(posedge mclk);
        swap <= ~swap;
        settle(4);
        u = upper;
        settle(1);
        check({15'h0, upper}, {15'h0, ~u});
        do_reset();
        settle(1);
        check(act, filter_cfg_pkg::CFG_RESET);
        u_cfg_writer_model.put(5'h1E, 16'h00AB);
        u_cfg_writer_model.put(5'h00, 16'hFF54);
        settle(1);
        check(act, filter_cfg_pkg::CFG_RESET);
        check(pend, 16'hAB00);
        u_cfg_writer_model.host_word(16'h9C00, 1'b1);
        check(act, 16'h9C00);
        do_reset();
        u_cfg_writer_model.eprom_word(16'h4C00, 0);
        settle(1);
        check(act, 16'h4C00);
        check({15'h0, sel}, 16'h0000);
        u_cfg_writer_model.eprom_word(16'h1C00, 2);
        settle(1);
        check(pend, 16'h1C00);
        check(act, 16'h4C00);
        wrap_up();
    end
endmodule
bind filter_configuration filter_configuration_assertions u_chk (.MCLK_IN,
    .RESETN_IN, .WRITE_EN_IN, .BYTE_MODE_IN, .CONFIG_WORD_SELECT_IN,
    .EPROM_LOAD_IN, .EPROM_BYTE_STROBE_IN, .BANK_SWAP_IN, .BANK_PIN_IN,
    .WDATA_IN, .CONFIG_WORD_SELECT_OUT, .ACTIVE_CFG_OUT, .PENDING_CFG_OUT,
    .FILTER_MODE_OUT, .RATE_SEL_OUT, .DECIMATE_OUT, .ROLE_OUT,
    .UPPER_BANK_OUT, .SAMPLE_TICK_OUT);
`default_nettype wire
